//--- logic/pts_pkg.sv
// constants, register map and shared decode for the time-base select and auto-shutdown block
// assumes a 32-bit apb master and a single core clock
package pts_pkg;

	localparam int unsigned ADDR_W = 12;
	localparam int unsigned DATA_W = 32;

	// register byte offsets
	localparam logic [ADDR_W-1:0] OFS_TIMER_SEL = 12'h000;
	localparam logic [ADDR_W-1:0] OFS_SHUTDOWN_CTL = 12'h004;
	localparam logic [ADDR_W-1:0] OFS_RESTART_CTL = 12'h008;
	localparam logic [ADDR_W-1:0] OFS_INT_STATUS = 12'h00C;
	localparam logic [ADDR_W-1:0] OFS_INT_MASK = 12'h010;

	// values after any reset
	localparam logic [1:0] RST_TIMER_SEL = 2'h0;
	localparam logic [7:0] RST_SHUTDOWN_CTL = 8'h00;
	localparam logic RST_RESTART_EN = 1'b0;
	localparam logic [1:0] RST_INT = 2'h0;
	localparam logic [7:0] RST_TIMEBASE = 8'h00;

	// shutdown and restart control field positions
	localparam int unsigned SD_FLAG_BIT = 7;
	localparam int unsigned SD_SRC_LSB = 4;
	localparam int unsigned SD_AC_LSB = 2;
	localparam int unsigned SD_BD_LSB = 0;
	localparam int unsigned RESTART_EN_BIT = 0;

	// interrupt status bit positions
	localparam int unsigned INT_SHUTDOWN_BIT = 0;
	localparam int unsigned INT_RESTART_BIT = 1;

	// time-base selector codes
	localparam logic [1:0] TSEL_FIRST = 2'h0;
	localparam logic [1:0] TSEL_SECOND = 2'h1;
	localparam logic [1:0] TSEL_THIRD = 2'h2;

	// shutdown source codes
	localparam logic [2:0] SRC_OFF = 3'h0;
	localparam logic [2:0] SRC_CMP1 = 3'h1;
	localparam logic [2:0] SRC_CMP2 = 3'h2;
	localparam logic [2:0] SRC_CMP_ANY = 3'h3;
	localparam logic [2:0] SRC_FLT = 3'h4;
	localparam logic [2:0] SRC_FLT_CMP1 = 3'h5;
	localparam logic [2:0] SRC_FLT_CMP2 = 3'h6;

	// is the selected shutdown condition present
	function automatic logic shutdown_trigger(input logic [2:0] src, input logic flt_low,
			input logic cmp1, input logic cmp2);
		unique case (src)
			SRC_CMP1: shutdown_trigger = cmp1;
			SRC_CMP2: shutdown_trigger = cmp2;
			SRC_CMP_ANY: shutdown_trigger = cmp1 | cmp2;
			SRC_FLT: shutdown_trigger = flt_low;
			SRC_FLT_CMP1: shutdown_trigger = flt_low | cmp1;
			SRC_FLT_CMP2: shutdown_trigger = flt_low | cmp2;
			default: shutdown_trigger = 1'b0;
		endcase
	endfunction : shutdown_trigger

endpackage : pts_pkg

//--- logic/pts_sync2.sv
// two flip-flop synchroniser for one level from outside the core clock domain
// assumes the input changes slowly compared with the core clock
`timescale 1ns/1ps
module pts_sync2 #(
	parameter logic INIT = 1'b0
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic async_in,
	output logic sync_out
);
	logic meta_reg;

	// the first stage feeds only the second
	always_ff @(posedge core_clk) begin
		if (rst) begin
			meta_reg <= INIT;
			sync_out <= INIT;
		end else if (ce) begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end
endmodule : pts_sync2

//--- logic/pts_pair_out.sv
// output stage of one pin pair: pass-through or shutdown state, registered
// assumes the pwm core supplies the normal pin levels on the same clock
`timescale 1ns/1ps
module pts_pair_out (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic shut,
	input wire logic [1:0] sd_state,
	input wire logic in_p,
	input wire logic in_q,
	output logic out_p,
	output logic out_q,
	output logic oe_p,
	output logic oe_q
);
	always_ff @(posedge core_clk) begin
		if (rst) begin
			out_p <= 1'b0;
			out_q <= 1'b0;
			oe_p <= 1'b0;
			oe_q <= 1'b0;
		end else if (ce) begin
			if (!shut) begin
				out_p <= in_p;
				out_q <= in_q;
				oe_p <= 1'b1;
				oe_q <= 1'b1;
			end else if (sd_state[1]) begin
				// tri-state: level parked low so nothing toggles behind a released pin
				out_p <= 1'b0;
				out_q <= 1'b0;
				oe_p <= 1'b0;
				oe_q <= 1'b0;
			end else begin
				out_p <= sd_state[0];
				out_q <= sd_state[0];
				oe_p <= 1'b1;
				oe_q <= 1'b1;
			end
		end
	end
endmodule : pts_pair_out

//--- logic/pts_top.sv
// channel-five time-base select and auto-shutdown control with an apb register slave
// assumes one core clock, synchronous reset, fault pin and comparator outputs asynchronous
//
// The APB register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps

// Notes on behaviour
// - timer select upper six bits read zero
// - selector picks first, second, third timer
// - all bits read/write, cleared by reset
// - flag set holds outputs in shutdown state
// - source code chooses fault/comparator trigger
// - ac pair: 1x tri-state, 01 high
// - bd pair: 1x tri-state, 01 high
// - restart enable auto-clears flag when event gone
module pts_top (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [pts_pkg::ADDR_W-1:0] paddr,
	input wire logic [pts_pkg::DATA_W-1:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [pts_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic fault_input_pin,
	input wire logic first_comparator_out,
	input wire logic second_comparator_out,
	input wire logic [7:0] first_8bit_timer_cnt,
	input wire logic [7:0] second_8bit_timer_cnt,
	input wire logic [7:0] third_8bit_timer_cnt,
	input wire logic pwm_in_a,
	input wire logic pwm_in_b,
	input wire logic pwm_in_c,
	input wire logic pwm_in_d,
	output logic pwm_out_a,
	output logic pwm_out_b,
	output logic pwm_out_c,
	output logic pwm_out_d,
	output logic pwm_oe_a,
	output logic pwm_oe_b,
	output logic pwm_oe_c,
	output logic pwm_oe_d,
	output logic [7:0] ch5_timebase_cnt,
	output logic shutdown_event_flag,
	output logic irq
);
	import pts_pkg::*;

	logic [1:0] ch5_timebase_sel_reg;
	logic [2:0] shutdown_source_sel_reg;
	logic [1:0] pair_ac_shutdown_state_reg;
	logic [1:0] pair_bd_shutdown_state_reg;
	logic auto_restart_enable_reg;
	logic [1:0] int_status_reg;
	logic [1:0] int_mask_reg;
	logic flag_next;
	logic [1:0] int_status_next;
	logic fault_sync;
	logic cmp1_sync;
	logic cmp2_sync;
	logic trigger;
	logic setup_phase;
	logic access_done;
	logic wr_en;
	logic rd_hit;
	logic [DATA_W-1:0] rd_data;
	logic shut_set;
	logic auto_clear;

	// register hit for an address
	function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
		addr_hit = (a == ofs);
	endfunction : addr_hit

	function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
		addr_mapped = addr_hit(a, OFS_TIMER_SEL) | addr_hit(a, OFS_SHUTDOWN_CTL) |
			addr_hit(a, OFS_RESTART_CTL) | addr_hit(a, OFS_INT_STATUS) | addr_hit(a, OFS_INT_MASK);
	endfunction : addr_mapped

	// fault pin idles high, so its synchroniser resets high to avoid a false trip
	pts_sync2 #(.INIT(1'b1)) u_sync_fault (
		.core_clk(core_clk),
		.rst(rst),
		.ce(ce),
		.async_in(fault_input_pin),
		.sync_out(fault_sync)
	);

	pts_sync2 #(.INIT(1'b0)) u_sync_cmp1 (
		.core_clk(core_clk),
		.rst(rst),
		.ce(ce),
		.async_in(first_comparator_out),
		.sync_out(cmp1_sync)
	);

	pts_sync2 #(.INIT(1'b0)) u_sync_cmp2 (
		.core_clk(core_clk),
		.rst(rst),
		.ce(ce),
		.async_in(second_comparator_out),
		.sync_out(cmp2_sync)
	);

	assign trigger = shutdown_trigger(shutdown_source_sel_reg, ~fault_sync, cmp1_sync, cmp2_sync);

	// apb: no wait states, pready comes from a flop raised in the setup cycle
	assign setup_phase = psel & ~penable;
	assign access_done = psel & penable & pready;
	assign wr_en = access_done & pwrite & pstrb[0] & addr_mapped(paddr);
	assign rd_hit = addr_mapped(paddr);

	always_comb begin
		rd_data = '0;
		if (addr_hit(paddr, OFS_TIMER_SEL)) begin
			rd_data[1:0] = ch5_timebase_sel_reg;
		end else if (addr_hit(paddr, OFS_SHUTDOWN_CTL)) begin
			rd_data[SD_FLAG_BIT] = shutdown_event_flag;
			rd_data[SD_SRC_LSB +: 3] = shutdown_source_sel_reg;
			rd_data[SD_AC_LSB +: 2] = pair_ac_shutdown_state_reg;
			rd_data[SD_BD_LSB +: 2] = pair_bd_shutdown_state_reg;
		end else if (addr_hit(paddr, OFS_RESTART_CTL)) begin
			rd_data[RESTART_EN_BIT] = auto_restart_enable_reg;
		end else if (addr_hit(paddr, OFS_INT_STATUS)) begin
			rd_data[1:0] = int_status_reg;
		end else if (addr_hit(paddr, OFS_INT_MASK)) begin
			rd_data[1:0] = int_mask_reg;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			pready <= 1'b0;
			prdata <= '0;
			pslverr <= 1'b0;
		end else if (ce) begin
			pready <= setup_phase;
			if (setup_phase) begin
				prdata <= pwrite ? '0 : rd_data;
				pslverr <= ~rd_hit;
			end
		end
	end

	// configuration registers; only the low two bits of the timer select exist
	always_ff @(posedge core_clk) begin
		if (rst) begin
			ch5_timebase_sel_reg <= RST_TIMER_SEL;
			shutdown_source_sel_reg <= RST_SHUTDOWN_CTL[SD_SRC_LSB +: 3];
			pair_ac_shutdown_state_reg <= RST_SHUTDOWN_CTL[SD_AC_LSB +: 2];
			pair_bd_shutdown_state_reg <= RST_SHUTDOWN_CTL[SD_BD_LSB +: 2];
			auto_restart_enable_reg <= RST_RESTART_EN;
			int_mask_reg <= RST_INT;
		end else if (ce && wr_en) begin
			if (addr_hit(paddr, OFS_TIMER_SEL)) begin
				ch5_timebase_sel_reg <= pwdata[1:0];
			end
			if (addr_hit(paddr, OFS_SHUTDOWN_CTL)) begin
				shutdown_source_sel_reg <= pwdata[SD_SRC_LSB +: 3];
				pair_ac_shutdown_state_reg <= pwdata[SD_AC_LSB +: 2];
				pair_bd_shutdown_state_reg <= pwdata[SD_BD_LSB +: 2];
			end
			if (addr_hit(paddr, OFS_RESTART_CTL)) begin
				auto_restart_enable_reg <= pwdata[RESTART_EN_BIT];
			end
			if (addr_hit(paddr, OFS_INT_MASK)) begin
				int_mask_reg <= pwdata[1:0];
			end
		end
	end

	// shutdown flag: a live trigger beats both a software clear and the auto-restart clear
	assign shut_set = trigger;
	assign auto_clear = auto_restart_enable_reg & shutdown_event_flag & ~trigger;

	always_comb begin
		flag_next = shutdown_event_flag;
		if (wr_en && addr_hit(paddr, OFS_SHUTDOWN_CTL)) begin
			flag_next = pwdata[SD_FLAG_BIT];
		end else if (auto_clear) begin
			flag_next = 1'b0;
		end
		if (shut_set) begin
			flag_next = 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			shutdown_event_flag <= RST_SHUTDOWN_CTL[SD_FLAG_BIT];
		end else if (ce) begin
			shutdown_event_flag <= flag_next;
		end
	end

	// sticky interrupt events, write one to clear, a new event wins
	always_comb begin
		int_status_next = int_status_reg;
		if (wr_en && addr_hit(paddr, OFS_INT_STATUS)) begin
			int_status_next = int_status_reg & ~pwdata[1:0];
		end
		if (flag_next && !shutdown_event_flag) begin
			int_status_next[INT_SHUTDOWN_BIT] = 1'b1;
		end
		if (auto_clear && !shut_set) begin
			int_status_next[INT_RESTART_BIT] = 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			int_status_reg <= RST_INT;
			irq <= 1'b0;
		end else if (ce) begin
			int_status_reg <= int_status_next;
			irq <= |(int_status_next & int_mask_reg);
		end
	end

	// time base for channel five; reserved code holds the count at zero
	always_ff @(posedge core_clk) begin
		if (rst) begin
			ch5_timebase_cnt <= RST_TIMEBASE;
		end else if (ce) begin
			unique case (ch5_timebase_sel_reg)
				TSEL_FIRST: ch5_timebase_cnt <= first_8bit_timer_cnt;
				TSEL_SECOND: ch5_timebase_cnt <= second_8bit_timer_cnt;
				TSEL_THIRD: ch5_timebase_cnt <= third_8bit_timer_cnt;
				default: ch5_timebase_cnt <= RST_TIMEBASE;
			endcase
		end
	end

	// the pin stages use the stored flag, so a software-set flag also shuts down
	pts_pair_out u_pair_ac (
		.core_clk(core_clk),
		.rst(rst),
		.ce(ce),
		.shut(shutdown_event_flag),
		.sd_state(pair_ac_shutdown_state_reg),
		.in_p(pwm_in_a),
		.in_q(pwm_in_c),
		.out_p(pwm_out_a),
		.out_q(pwm_out_c),
		.oe_p(pwm_oe_a),
		.oe_q(pwm_oe_c)
	);

	pts_pair_out u_pair_bd (
		.core_clk(core_clk),
		.rst(rst),
		.ce(ce),
		.shut(shutdown_event_flag),
		.sd_state(pair_bd_shutdown_state_reg),
		.in_p(pwm_in_b),
		.in_q(pwm_in_d),
		.out_p(pwm_out_b),
		.out_q(pwm_out_d),
		.oe_p(pwm_oe_b),
		.oe_q(pwm_oe_d)
	);

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	property p_tsel_upper_zero;
		(psel && penable && pready && !pwrite && addr_hit(paddr, OFS_TIMER_SEL)) |-> (prdata[7:2] == 6'h00);
	endproperty
	a_tsel_upper_zero: assert property (p_tsel_upper_zero) else $error("timer select upper bits not zero");

	property p_tbase_second;
		(ce && ch5_timebase_sel_reg == TSEL_SECOND) |=> (ch5_timebase_cnt == $past(second_8bit_timer_cnt));
	endproperty
	a_tbase_second: assert property (p_tbase_second) else $error("second timer not selected");

	property p_tbase_third;
		(ce && ch5_timebase_sel_reg == TSEL_THIRD) |=> (ch5_timebase_cnt == $past(third_8bit_timer_cnt));
	endproperty
	a_tbase_third: assert property (p_tbase_third) else $error("third timer not selected");

	// checked at the first edge after release, since the attempt is disabled while rst is high
	property p_reset_clear;
		@(posedge core_clk) $fell(rst) |-> (ch5_timebase_sel_reg == 2'h0 && shutdown_source_sel_reg == 3'h0 &&
			!shutdown_event_flag && pair_ac_shutdown_state_reg == 2'h0 && pair_bd_shutdown_state_reg == 2'h0 &&
			!auto_restart_enable_reg);
	endproperty
	a_reset_clear: assert property (p_reset_clear) else $error("registers not cleared by reset");

	property p_normal_pass;
		(ce && !shutdown_event_flag) |=> (pwm_out_a == $past(pwm_in_a) && pwm_oe_a && pwm_out_d == $past(pwm_in_d));
	endproperty
	a_normal_pass: assert property (p_normal_pass) else $error("outputs not normal while flag clear");

	property p_trigger_sets;
		(ce && trigger) |=> shutdown_event_flag;
	endproperty
	a_trigger_sets: assert property (p_trigger_sets) else $error("trigger did not set shutdown flag");

	property p_ac_tristate;
		(ce && shutdown_event_flag && pair_ac_shutdown_state_reg[1]) |=> (!pwm_oe_a && !pwm_oe_c);
	endproperty
	a_ac_tristate: assert property (p_ac_tristate) else $error("ac pair not released");

	property p_bd_high;
		(ce && shutdown_event_flag && pair_bd_shutdown_state_reg == 2'h1) |=>
			(pwm_oe_b && pwm_oe_d && pwm_out_b && pwm_out_d);
	endproperty
	a_bd_high: assert property (p_bd_high) else $error("bd pair not driven high");

	property p_low_state;
		(ce && shutdown_event_flag && pair_ac_shutdown_state_reg == 2'h0) |=>
			(pwm_oe_a && !pwm_out_a && !pwm_out_c);
	endproperty
	a_low_state: assert property (p_low_state) else $error("ac pair not driven low");

	property p_ac_high;
		(ce && shutdown_event_flag && pair_ac_shutdown_state_reg == 2'h1) |=>
			(pwm_oe_a && pwm_oe_c && pwm_out_a && pwm_out_c);
	endproperty
	a_ac_high: assert property (p_ac_high) else $error("ac pair not driven high");

	property p_bd_tristate;
		(ce && shutdown_event_flag && pair_bd_shutdown_state_reg[1]) |=> (!pwm_oe_b && !pwm_oe_d);
	endproperty
	a_bd_tristate: assert property (p_bd_tristate) else $error("bd pair not released");

	property p_bd_low;
		(ce && shutdown_event_flag && pair_bd_shutdown_state_reg == 2'h0) |=>
			(pwm_oe_b && pwm_oe_d && !pwm_out_b && !pwm_out_d);
	endproperty
	a_bd_low: assert property (p_bd_low) else $error("bd pair not driven low");

	property p_flag_hold;
		(ce && shutdown_event_flag && !auto_restart_enable_reg && !wr_en) |=> shutdown_event_flag;
	endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("flag cleared without software");

	property p_irq_quiet;
		(ce && (int_status_next & int_mask_reg) == 2'h0) |=> !irq;
	endproperty
	a_irq_quiet: assert property (p_irq_quiet) else $error("interrupt raised with nothing pending");

	property p_auto_restart;
		(ce && auto_restart_enable_reg && shutdown_event_flag && !trigger && !wr_en) |=> !shutdown_event_flag;
	endproperty
	a_auto_restart: assert property (p_auto_restart) else $error("flag not cleared by auto restart");

	property p_irq_level;
		(ce && (int_status_next & int_mask_reg) != 2'h0) |=> irq;
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("interrupt not raised");

	c_shutdown: cover property (ce && !shutdown_event_flag ##1 shutdown_event_flag);
	c_restart: cover property (auto_restart_enable_reg && shutdown_event_flag ##1 !shutdown_event_flag);
	c_read: cover property (psel && penable && pready && !pwrite);
	c_irq: cover property (!irq ##1 irq);

endmodule : pts_top

//--- testbench/pts_stage_model.sv
// far-side model: fault pin and two comparators driven on command, pin pairs loaded by a power stage
// assumes the bench changes its commands just after a rising edge of core_clk
`timescale 1ns/1ps
module pts_stage_model (
	input wire logic core_clk,
	input wire logic slow,
	input wire logic [2:0] trip,
	input wire logic [3:0] pin_out,
	input wire logic [3:0] pin_oe,
	output logic fault_input_pin,
	output logic first_comparator_out,
	output logic second_comparator_out,
	output logic [3:0] pin_lvl
);
	logic [2:0] trip_reg;
	logic [2:0] act;
	// a slow source shows its condition one cycle late
	always_ff @(posedge core_clk) begin
		trip_reg <= trip;
	end
	assign act = slow ? trip_reg : trip;
	// fault line idles high on its pull-up and is pulled low to signal a fault
	assign fault_input_pin = ~act[0];
	assign first_comparator_out = act[1];
	assign second_comparator_out = act[2];
	// gate inputs have pull-downs, so a released pin reads low
	assign pin_lvl = pin_oe & pin_out;
endmodule : pts_stage_model

//--- testbench/tb.sv
// self-checking bench for the time-base select and auto-shutdown block
// assumes apb slave answers with pready; fault and comparators come from the stage model
`timescale 1ns/1ps
module tb;
	import pts_pkg::*;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [ADDR_W-1:0] paddr = 12'h000;
	logic [DATA_W-1:0] pwdata = 32'h0;
	logic [DATA_W-1:0] prdata, rd, rnd;
	logic pready, pslverr, err, flag, irq, flt, c1, c2, exp_f;
	logic slow = 1'b0;
	logic [2:0] trip = 3'h0;
	logic [7:0] t1 = 8'h00, t2 = 8'h00, t3 = 8'h00, tb_cnt;
	logic [3:0] pin_in = 4'h0, outs, oes, lvl;
	int seed = 32'hF1E0;
	int mismatches = 0;
	int compares = 0;

	always #2.5 core_clk = ~core_clk;

	pts_top pts_top_i (.core_clk(core_clk), .rst(rst), .ce(1'b1), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .fault_input_pin(flt), .first_comparator_out(c1), .second_comparator_out(c2),
		.first_8bit_timer_cnt(t1), .second_8bit_timer_cnt(t2), .third_8bit_timer_cnt(t3),
		.pwm_in_a(pin_in[0]), .pwm_in_b(pin_in[1]), .pwm_in_c(pin_in[2]), .pwm_in_d(pin_in[3]),
		.pwm_out_a(outs[0]), .pwm_out_b(outs[1]), .pwm_out_c(outs[2]), .pwm_out_d(outs[3]),
		.pwm_oe_a(oes[0]), .pwm_oe_b(oes[1]), .pwm_oe_c(oes[2]), .pwm_oe_d(oes[3]),
		.ch5_timebase_cnt(tb_cnt), .shutdown_event_flag(flag), .irq(irq));

	pts_stage_model pts_stage_model_i (.core_clk(core_clk), .slow(slow), .trip(trip), .pin_out(outs),
		.pin_oe(oes), .fault_input_pin(flt), .first_comparator_out(c1), .second_comparator_out(c2),
		.pin_lvl(lvl));

	task wrap_up;
		if (mismatches == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : wrap_up

	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// one apb transfer; read data and error land in rd and err
	task apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		int n;
		n = 0;
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) begin
			chk("apb pready", {31'h0, pready}, 32'h1);
			wrap_up();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// t holds {cmp2, cmp1, fault}; code 7 names no source
	function automatic logic trig_f(input logic [2:0] s, input logic [2:0] t);
		return (s != 3'h7) & ((s[2] & t[0]) | (s[0] & t[1]) | (s[1] & t[2]));
	endfunction : trig_f

	function automatic logic [7:0] tbase(input logic [1:0] c);
		return (c == 2'h0) ? t1 : (c == 2'h1) ? t2 : (c == 2'h2) ? t3 : 8'h00;
	endfunction : tbase

	// {oe d,c,b,a, level d,c,b,a} while shut down
	function automatic logic [7:0] shut_exp(input logic [1:0] ac, input logic [1:0] bd);
		logic oa, ob;
		oa = ~ac[1];
		ob = ~bd[1];
		return {ob, oa, ob, oa, ob & bd[0], oa & ac[0], ob & bd[0], oa & ac[0]};
	endfunction : shut_exp

	initial begin
		repeat (10) @(posedge core_clk);
		rst <= 1'b0;
		for (int a = 0; a <= 16; a += 4) begin
			apb(1'b0, a[11:0], 32'h0);
			chk("reset value", rd, 32'h0);
		end
		apb(1'b0, 12'h014, 32'h0);
		chk("unmapped", {err, rd[30:0]}, 32'h80000000);
		rnd = $random(seed);
		t1 <= rnd[7:0];
		t2 <= rnd[15:8];
		t3 <= rnd[23:16];
		for (int c = 0; c < 4; c++) begin
			rnd = $random(seed);
			apb(1'b1, OFS_TIMER_SEL, {rnd[31:2], c[1:0]});
			apb(1'b0, OFS_TIMER_SEL, 32'h0);
			chk("timer select", rd, {30'h0, c[1:0]});
			chk("timebase count", {24'h0, tb_cnt}, {24'h0, tbase(c[1:0])});
		end
		rnd = $random(seed);
		apb(1'b1, OFS_SHUTDOWN_CTL, {24'h0, rnd[7], 3'h0, rnd[3:0]});
		apb(1'b0, OFS_SHUTDOWN_CTL, 32'h0);
		chk("control readback", rd, {24'h0, rnd[7], 3'h0, rnd[3:0]});
		for (int k = 0; k < 4; k++) begin
			apb(1'b1, OFS_SHUTDOWN_CTL, {24'h0, 1'b1, 3'h0, k[1:0], ~k[1:0]});
			repeat (3) @(posedge core_clk);
			chk("shutdown pins", {24'h0, oes, lvl}, {24'h0, shut_exp(k[1:0], ~k[1:0])});
			apb(1'b1, OFS_SHUTDOWN_CTL, 32'h0);
			rnd = $random(seed);
			pin_in <= rnd[3:0];
			repeat (3) @(posedge core_clk);
			chk("normal pins", {24'h0, oes, lvl}, {24'h0, 4'hF, pin_in});
		end
		// every source code against each single condition; no auto restart yet
		for (int s = 0; s < 8; s++) begin
			for (int t = 0; t < 3; t++) begin
				rnd = $random(seed);
				slow <= rnd[0];
				apb(1'b1, OFS_SHUTDOWN_CTL, {24'h0, 1'b0, s[2:0], 4'h0});
				trip <= 3'h1 << t;
				repeat (7) @(posedge core_clk);
				exp_f = trig_f(s[2:0], 3'h1 << t);
				chk("flag on trip", {31'h0, flag}, {31'h0, exp_f});
				trip <= 3'h0;
				repeat (7) @(posedge core_clk);
				apb(1'b0, OFS_SHUTDOWN_CTL, 32'h0);
				chk("flag held", rd, {24'h0, exp_f, s[2:0], 4'h0});
				apb(1'b1, OFS_SHUTDOWN_CTL, 32'h0);
			end
		end
		chk("masked irq", {31'h0, irq}, 32'h0);
		apb(1'b1, OFS_INT_STATUS, 32'h3);
		apb(1'b1, OFS_INT_MASK, 32'h1);
		apb(1'b1, OFS_RESTART_CTL, 32'h1);
		apb(1'b1, OFS_SHUTDOWN_CTL, {24'h0, 1'b0, SRC_FLT, 4'h0});
		trip <= 3'h1;
		repeat (7) @(posedge core_clk);
		chk("flag and irq", {30'h0, flag, irq}, 32'h3);
		trip <= 3'h0;
		repeat (7) @(posedge core_clk);
		chk("auto restart", {31'h0, flag}, 32'h0);
		apb(1'b0, OFS_INT_STATUS, 32'h0);
		chk("int status", rd, 32'h3);
		apb(1'b1, OFS_INT_STATUS, 32'h3);
		apb(1'b0, OFS_INT_STATUS, 32'h0);
		chk("status cleared", {rd[30:0], irq}, 32'h0);
		// a second reset in mid-run must clear what software left behind
		apb(1'b1, OFS_TIMER_SEL, 32'h2);
		apb(1'b1, OFS_SHUTDOWN_CTL, 32'hFF);
		rst <= 1'b1;
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		apb(1'b0, OFS_TIMER_SEL, 32'h0);
		chk("timer select after reset", rd, 32'h0);
		apb(1'b0, OFS_SHUTDOWN_CTL, 32'h0);
		chk("control after reset", rd, 32'h0);
		apb(1'b0, OFS_RESTART_CTL, 32'h0);
		chk("restart after reset", {rd[29:0], flag, irq}, 32'h0);
		wrap_up();
	end
endmodule : tb
